// *** src/brf_pkg.sv ***
package brf_pkg;
	// Register map (byte addresses on a 32-bit Wishbone)
	localparam logic [7:0] TUNE_OFFSET = 8'h04;
	localparam logic [7:0] FAULT_OFFSET = 8'h06;
	localparam logic [7:0] EVT_STAT_OFFSET = 8'h10;
	localparam logic [7:0] EVT_MASK_OFFSET = 8'h14;
	localparam logic [7:0] RAMP_STAT_OFFSET = 8'h18;
	localparam logic [7:0] SHORT_IN_OFFSET = 8'h1c;

	localparam logic [15:0] TUNE_RESET = 16'h00a3;
	localparam logic [15:0] FAULT_RESET = 16'h0100;

	// Field positions
	localparam int RAMP_CODE_LSB = 5;
	localparam int DITHER_LSB = 2;
	localparam int SMOOTH_BIT = 1;
	localparam int GND_CHECK_BIT = 8;
	localparam int STRINGS = 4;

	// Ramp duration codes
	localparam logic [2:0] RAMP_OFF = 3'h0;
	localparam logic [2:0] RAMP_1MS = 3'h1;
	localparam logic [2:0] RAMP_2MS = 3'h2;
	localparam logic [2:0] RAMP_50MS = 3'h3;
	localparam logic [2:0] RAMP_100MS = 3'h4;
	localparam logic [2:0] RAMP_200MS = 3'h5;
	localparam logic [2:0] RAMP_300MS = 3'h6;
	localparam logic [2:0] RAMP_500MS = 3'h7;

	// Ramp lengths in 1 ms ticks
	localparam logic [31:0] LEN_OFF = 32'h0;
	localparam logic [31:0] LEN_1MS = 32'h1;
	localparam logic [31:0] LEN_2MS = 32'h2;
	localparam logic [31:0] LEN_50MS = 32'h32;
	localparam logic [31:0] LEN_100MS = 32'h64;
	localparam logic [31:0] LEN_200MS = 32'hc8;
	localparam logic [31:0] LEN_300MS = 32'h12c;
	localparam logic [31:0] LEN_500MS = 32'h1f4;
	// 50 ms code stretched by the smoothing ratio, rounded down
	localparam logic [31:0] LEN_50MS_SMOOTH = 32'h3e;

	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
	// Smoothed ramps run this many quarters of the linear length
	localparam int SMOOTH_NUM = 5;
	localparam int SMOOTH_DEN = 4;

	// Event bits
	localparam int EV_RAMP_DONE = 0;
	localparam int EV_GND_FAULT = 1;
	localparam int EV_SHORT_LSB = 2;
	localparam int EV_BITS = 6;

	typedef struct packed {
		logic [2:0] ramp_code;
		logic [2:0] dither_depth;
		logic smooth_ramp_on;
	} brf_tune_s;

	typedef struct packed {
		logic string_ground_fault_check_on;
		logic [STRINGS-1:0] short_fault_mask;
	} brf_fault_s;
endpackage

// *** src/brf_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Codes 3h..7h map to 50..500 ms linear
// R2 - Smoothed ramping lengthens and smooths transitions
// R3 - Software uses 1/2 ms only when linear
// R4 - 50 to 500 ms accepted either style
// R5 - Bit 1 smooth ramp, resets to 1
// R6 - Tuning bit 0 reserved, RW, resets 1
// R7 - Fault config at 06h, resets 100h
// R8 - Bit 8 enables string ground-short check
// R9 - Bits 0..3 mask string short faults
// R10 - Software writes zero to bits 7..4
// R11 - Codes 0..2 off/1/2 ms, bits 7:5, reset 5h
// R12 - Fault bits 15..9 read back, no effect
module brf_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Analog side
	input wire logic ramp_request,
	input wire logic boost_active,
	input wire logic gnd_short_raw,
	input wire logic [brf_pkg::STRINGS-1:0] string_short_raw,
	// Outputs to driver core
	output brf_pkg::brf_tune_s tune_cfg,
	output brf_pkg::brf_fault_s fault_cfg,
	output logic ramp_busy,
	output logic [brf_pkg::STRINGS-1:0] string_fault,
	output logic gnd_fault,
	output logic irq
);
	import brf_pkg::*;

	logic [15:0] tune_q;
	logic [15:0] fault_q;
	logic [EV_BITS-1:0] stat_q;
	logic [EV_BITS-1:0] mask_q;
	logic [31:0] ramp_cnt_q;
	logic [31:0] tick_q;
	logic ramp_busy_q;
	logic ramp_done_q;
	logic [2:0] req_sync_q;
	logic [1:0] boost_sync_q;
	logic [1:0] gnd_sync_q;
	logic [STRINGS-1:0] short_s1_q;
	logic [STRINGS-1:0] short_s2_q;
	logic [STRINGS-1:0] string_fault_q;
	logic gnd_fault_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic irq_q;

	// Ramp length in 1 ms ticks, before smoothing
	function automatic logic [31:0] ramp_ms(input logic [2:0] code);
		case (code)
			RAMP_1MS: ramp_ms = LEN_1MS; // R11
			RAMP_2MS: ramp_ms = LEN_2MS; // R11
			RAMP_50MS: ramp_ms = LEN_50MS; // R1
			RAMP_100MS: ramp_ms = LEN_100MS; // R1
			RAMP_200MS: ramp_ms = LEN_200MS; // R1
			RAMP_300MS: ramp_ms = LEN_300MS; // R1
			RAMP_500MS: ramp_ms = LEN_500MS; // R1
			default: ramp_ms = LEN_OFF; // R11
		endcase
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] dat,
			input logic [3:0] sel);
		merge = old;
		if (sel[0])
			merge[7:0] = dat[7:0];
		if (sel[1])
			merge[15:8] = dat[15:8];
	endfunction

	logic req;
	logic wr;
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;

	// Bus answer one cycle after request; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= req;
			dat_q <= 32'h0;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					TUNE_OFFSET: dat_q <= {16'h0, tune_q}; // R6
					FAULT_OFFSET: dat_q <= {16'h0, fault_q}; // R12
					EVT_STAT_OFFSET: dat_q <= {26'h0, stat_q};
					EVT_MASK_OFFSET: dat_q <= {26'h0, mask_q};
					RAMP_STAT_OFFSET: dat_q <= {31'h0, ramp_busy_q};
					SHORT_IN_OFFSET: dat_q <= {27'h0, gnd_sync_q[1], short_s2_q};
					default: dat_q <= 32'h0;
				endcase
			end
		end
	end

	// Configuration registers; all bits plain RW
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tune_q <= TUNE_RESET; // R5 R6 R11
			fault_q <= FAULT_RESET; // R7
		end else if (wr) begin
			if (wb_adr_i == TUNE_OFFSET)
				tune_q <= merge(tune_q, wb_dat_i, wb_sel_i);
			if (wb_adr_i == FAULT_OFFSET)
				fault_q <= merge(fault_q, wb_dat_i, wb_sel_i); // R7 R12
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			mask_q <= '0;
		else if (wr && wb_adr_i == EVT_MASK_OFFSET && wb_sel_i[0])
			mask_q <= wb_dat_i[EV_BITS-1:0];
	end

	// Pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_sync_q <= '0;
			boost_sync_q <= '0;
			gnd_sync_q <= '0;
			short_s1_q <= '0;
			short_s2_q <= '0;
		end else begin
			req_sync_q <= {req_sync_q[1:0], ramp_request};
			boost_sync_q <= {boost_sync_q[0], boost_active};
			gnd_sync_q <= {gnd_sync_q[0], gnd_short_raw};
			short_s1_q <= string_short_raw;
			short_s2_q <= short_s1_q;
		end
	end

	logic ramp_start;
	logic [2:0] code;
	logic smooth;
	logic [31:0] ramp_len;
	assign ramp_start = req_sync_q[1] && !req_sync_q[2];
	assign code = tune_q[RAMP_CODE_LSB +: 3];
	assign smooth = tune_q[SMOOTH_BIT];
	// Smoothed mode stretches time; 50-500 ms codes legal either way
	assign ramp_len = smooth ? (ramp_ms(code) * SMOOTH_NUM) / SMOOTH_DEN
		: ramp_ms(code); // R2 R4 R5

	// Ramp timer; a new request restarts it at the current code
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tick_q <= '0;
			ramp_cnt_q <= '0;
			ramp_busy_q <= 1'b0;
			ramp_done_q <= 1'b0;
		end else begin
			ramp_done_q <= 1'b0;
			if (ramp_start) begin
				tick_q <= '0;
				ramp_cnt_q <= ramp_len; // R1
				ramp_busy_q <= (ramp_len != 32'h0); // R11
				ramp_done_q <= (ramp_len == 32'h0);
			end else if (ramp_busy_q) begin
				if (tick_q == TICK_CYCLES - 1) begin
					tick_q <= '0;
					ramp_cnt_q <= ramp_cnt_q - 32'h1;
					if (ramp_cnt_q == 32'h1) begin
						ramp_busy_q <= 1'b0;
						ramp_done_q <= 1'b1;
					end
				end else begin
					tick_q <= tick_q + 32'h1;
				end
			end
		end
	end

	logic [STRINGS-1:0] short_ev;
	logic gnd_ev;
	// Masked strings never raise a fault; bits 7..4 have no effect
	assign short_ev = short_s2_q & ~fault_q[STRINGS-1:0]; // R9 R10
	assign gnd_ev = gnd_sync_q[1] && boost_sync_q[1] && fault_q[GND_CHECK_BIT]; // R8

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			string_fault_q <= '0;
			gnd_fault_q <= 1'b0;
		end else begin
			string_fault_q <= short_ev; // R9
			gnd_fault_q <= gnd_ev; // R8
		end
	end

	logic [EV_BITS-1:0] ev;
	assign ev = {short_ev, gnd_ev, ramp_done_q};

	// Sticky status: new event beats write-one-to-clear
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stat_q <= '0;
		end else if (wr && wb_adr_i == EVT_STAT_OFFSET && wb_sel_i[0]) begin
			stat_q <= (stat_q & ~wb_dat_i[EV_BITS-1:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			irq_q <= 1'b0;
		else
			irq_q <= |(stat_q & mask_q);
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign tune_cfg = '{ramp_code: code, dither_depth: tune_q[DITHER_LSB +: 3],
		smooth_ramp_on: smooth};
	assign fault_cfg = '{string_ground_fault_check_on: fault_q[GND_CHECK_BIT],
		short_fault_mask: fault_q[STRINGS-1:0]};
	assign ramp_busy = ramp_busy_q;
	assign string_fault = string_fault_q;
	assign gnd_fault = gnd_fault_q;
	assign irq = irq_q;

	// Reset state
	reset_values_a: assert property (@(posedge ref_clk) // R7
		$fell(reset) |->
		tune_q == TUNE_RESET && fault_q == FAULT_RESET)
		else $error("config reset value wrong");
	smooth_reset_a: assert property (@(posedge ref_clk) // R5 R6 R11
		$fell(reset) |->
		tune_cfg.smooth_ramp_on && tune_q[0] && tune_cfg.ramp_code == RAMP_200MS)
		else $error("tuning reset fields wrong");
	gnd_reset_a: assert property (@(posedge ref_clk) // R7 R8 R9
		$fell(reset) |->
		fault_cfg.string_ground_fault_check_on && fault_cfg.short_fault_mask == '0)
		else $error("fault reset fields wrong");
	irq_reset_a: assert property (@(posedge ref_clk)
		$fell(reset) |->
		!irq && !ramp_busy && stat_q == '0 && mask_q == '0)
		else $error("event state not cleared by reset");

	// Register bus
	bus_ack_a: assert property (@(posedge ref_clk) disable iff (reset)
		req |=>
		wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	read_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		!wb_ack_o |->
		wb_dat_o == 32'h0)
		else $error("read data outside ack");
	upper_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
		wb_dat_o[31:16] == 16'h0)
		else $error("upper read lanes not zero");
	tune_readback_a: assert property (@(posedge ref_clk) disable iff (reset) // R6
		wr && wb_adr_i == TUNE_OFFSET && wb_sel_i[1:0] == 2'h3 |=>
		tune_q == $past(wb_dat_i[15:0]))
		else $error("tuning config not stored");
	fault_readback_a: assert property (@(posedge ref_clk) disable iff (reset) // R12
		wr && wb_adr_i == FAULT_OFFSET && wb_sel_i[1:0] == 2'h3 |=>
		fault_q == $past(wb_dat_i[15:0]))
		else $error("fault config not stored");
	cfg_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // R6 R12
		!wr |=>
		$stable(tune_q) && $stable(fault_q))
		else $error("config changed without write");

	// Ramp timer
	ramp_length_a: assert property (@(posedge ref_clk) disable iff (reset) // R11
		ramp_start && code == RAMP_1MS && !smooth |=>
		ramp_busy [*8])
		else $error("1 ms ramp ended early");
	one_ms_count_a: assert property (@(posedge ref_clk) disable iff (reset) // R11
		ramp_start && code == RAMP_1MS && !smooth |=>
		ramp_cnt_q == LEN_1MS)
		else $error("1 ms ramp length wrong");
	ramp_off_a: assert property (@(posedge ref_clk) disable iff (reset) // R11
		ramp_start && code == RAMP_OFF |=>
		!ramp_busy && ramp_done_q)
		else $error("disabled ramp went busy");
	smooth_longer_a: assert property (@(posedge ref_clk) disable iff (reset) // R2
		ramp_start && smooth && code == RAMP_50MS |=>
		ramp_cnt_q == LEN_50MS_SMOOTH)
		else $error("smoothed ramp not stretched");
	smooth_accept_a: assert property (@(posedge ref_clk) disable iff (reset) // R4
		ramp_start && smooth && code >= RAMP_50MS |=>
		ramp_busy)
		else $error("smoothed long ramp refused");
	ramp_rise_a: assert property (@(posedge ref_clk) disable iff (reset) // R1
		ramp_start && ramp_len != 32'h0 |=>
		ramp_busy && tick_q == 32'h0)
		else $error("ramp did not start");
	busy_done_a: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(ramp_busy) |->
		ramp_done_q)
		else $error("ramp ended without done event");
	done_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
		ramp_done_q |->
		!ramp_busy)
		else $error("done event while ramp busy");
	tick_bound_a: assert property (@(posedge ref_clk) disable iff (reset)
		tick_q < TICK_CYCLES)
		else $error("tick counter out of range");

	// Fault paths; outputs lag a mask write by one cycle
	short_mask_a: assert property (@(posedge ref_clk) disable iff (reset) // R9
		(string_fault & $past(fault_q[STRINGS-1:0])) == '0)
		else $error("masked string raised fault");
	string_short_a: assert property (@(posedge ref_clk) disable iff (reset) // R9
		short_s2_q != '0 |=>
		string_fault == ($past(short_s2_q) & ~$past(fault_q[STRINGS-1:0])))
		else $error("unmasked string fault lost");
	gnd_check_a: assert property (@(posedge ref_clk) disable iff (reset) // R8
		!$past(fault_q[GND_CHECK_BIT]) |->
		!gnd_fault)
		else $error("ground fault while check off");
	gnd_detect_a: assert property (@(posedge ref_clk) disable iff (reset) // R8
		gnd_sync_q[1] && boost_sync_q[1] && fault_q[GND_CHECK_BIT] |=>
		gnd_fault)
		else $error("ground fault missed");
	gnd_boost_a: assert property (@(posedge ref_clk) disable iff (reset) // R8
		!boost_sync_q[1] |=>
		!gnd_fault)
		else $error("ground fault outside boost stage");

	// Events and interrupt
	stat_sets_a: assert property (@(posedge ref_clk) disable iff (reset)
		ev != '0 |=>
		(stat_q & $past(ev)) == $past(ev))
		else $error("event did not set status");
	stat_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
		wr && wb_adr_i == EVT_STAT_OFFSET && wb_sel_i[0] |=>
		(stat_q & $past(wb_dat_i[EV_BITS-1:0]) & ~$past(ev)) == '0)
		else $error("status not cleared by write");
	mask_write_a: assert property (@(posedge ref_clk) disable iff (reset)
		wr && wb_adr_i == EVT_MASK_OFFSET && wb_sel_i[0] |=>
		mask_q == $past(wb_dat_i[EV_BITS-1:0]))
		else $error("event mask not stored");
	irq_level_a: assert property (@(posedge ref_clk) disable iff (reset)
		(stat_q & mask_q) != '0 |=>
		irq)
		else $error("interrupt missing");
	irq_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
		(stat_q & mask_q) == '0 |=>
		!irq)
		else $error("interrupt without masked event");
endmodule // brf_regs
`default_nettype wire

// *** test/brf_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module brf_host (
	// Clock
	input wire logic ref_clk,
	// Wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat_w,
	input wire logic ack,
	input wire logic [31:0] dat_r
);
	import brf_pkg::*;
	initial begin
		{cyc, stb, we, adr, sel, dat_w} = '0;
	end
	// Request held until ack is sampled; ok low on timeout
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		// Fault bits 7..4 always sent as zero; bits 15..9 sent as given
		dat_w <= {16'h0, (a == FAULT_OFFSET) ? (d & 16'hff0f) : d};
		ok = 1'b0;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge ref_clk);
			ok = (ack === 1'b1);
		end
		q = dat_r[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
endmodule // brf_host
`default_nettype wire

// *** test/backlight_ramp_fault_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module backlight_ramp_fault_config_tb_top;
	import brf_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic cyc, stb, we, ack, ok, ramp_busy, gnd_fault, irq;
	logic [7:0] adr;
	logic [3:0] sel, string_fault;
	logic [31:0] dat_w, dat_r;
	logic ramp_request = 1'b0;
	logic boost_active = 1'b0;
	logic gnd_short_raw = 1'b0;
	logic [3:0] string_short_raw = 4'h0;
	logic [15:0] q, d;
	brf_tune_s tune_cfg;
	brf_fault_s fault_cfg;
	int err_count = 0;
	int n_checks = 0;
	int n, c;

	always #20 ref_clk = ~ref_clk;

	brf_host brf_host_inst (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat_w(dat_w), .ack(ack), .dat_r(dat_r));
	brf_regs brf_regs_inst (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
		.wb_ack_o(ack), .ramp_request(ramp_request), .boost_active(boost_active),
		.gnd_short_raw(gnd_short_raw), .string_short_raw(string_short_raw),
		.tune_cfg(tune_cfg), .fault_cfg(fault_cfg), .ramp_busy(ramp_busy),
		.string_fault(string_fault), .gnd_fault(gnd_fault), .irq(irq));

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
		brf_host_inst.xfer(w, a, v, q, ok);
		check(16'(ok), 16'h1);
		if (ok !== 1'b1)
			finish_test;
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	initial begin
		cycles(20);
		reset <= 1'b0;
		acc(1'b0, TUNE_OFFSET, 16'h0);
		check(q, 16'h00a3);
		acc(1'b0, FAULT_OFFSET, 16'h0);
		check(q, 16'h0100);
		check(16'(fault_cfg), 16'h0010);
		acc(1'b0, 8'h30, 16'h0);
		check(q, 16'h0);
		for (c = 0; c < 8; c++) begin
			// Short codes only with linear ramping
			d = 16'(c << 5) | 16'((c % 5) << 2) | ((c == 1 || c == 2) ? 16'h1 : 16'h3);
			acc(1'b1, TUNE_OFFSET, d);
			acc(1'b0, TUNE_OFFSET, 16'h0);
			check(q, d);
			check(16'(tune_cfg), 16'(d[7:1]));
		end
		check(16'(tune_cfg.smooth_ramp_on), 16'h1);
		string_short_raw <= 4'hf;
		boost_active <= 1'b1;
		gnd_short_raw <= 1'b1;
		acc(1'b1, FAULT_OFFSET, 16'hfe05);
		acc(1'b0, FAULT_OFFSET, 16'h0);
		check(q, 16'hfe05);
		cycles(5);
		check(16'(string_fault), 16'ha);
		check(16'(gnd_fault), 16'h0);
		acc(1'b1, FAULT_OFFSET, 16'h0100);
		cycles(5);
		check(16'(string_fault), 16'hf);
		check(16'(gnd_fault), 16'h1);
		acc(1'b0, SHORT_IN_OFFSET, 16'h0);
		check(q, 16'h001f);
		boost_active <= 1'b0;
		cycles(5);
		check(16'(gnd_fault), 16'h0);
		string_short_raw <= 4'h0;
		gnd_short_raw <= 1'b0;
		cycles(5);
		acc(1'b0, EVT_STAT_OFFSET, 16'h0);
		check(q, 16'h003e);
		check(16'(irq), 16'h0);
		acc(1'b1, EVT_STAT_OFFSET, 16'h003e);
		acc(1'b0, EVT_STAT_OFFSET, 16'h0);
		check(q, 16'h0);
		acc(1'b1, EVT_MASK_OFFSET, 16'h1);
		acc(1'b1, TUNE_OFFSET, 16'h0003);
		ramp_request <= 1'b1;
		cycles(8);
		acc(1'b0, EVT_STAT_OFFSET, 16'h0);
		check(q, 16'h1);
		check(16'(irq), 16'h1);
		acc(1'b1, EVT_STAT_OFFSET, 16'h1);
		cycles(2);
		check(16'(irq), 16'h0);
		ramp_request <= 1'b0;
		acc(1'b1, TUNE_OFFSET, 16'h0021);
		ramp_request <= 1'b1;
		for (n = 0; n < 10 && ramp_busy !== 1'b1; n++)
			cycles(1);
		for (n = 0; n < 30000 && ramp_busy === 1'b1; n++)
			cycles(1);
		// One millisecond is 25000 cycles
		check(16'(n >= 24999 && n <= 25001), 16'h1);
		cycles(3);
		check(16'(irq), 16'h1);
		// Smoothed 50 ms ramp only starts; its full length is out of reach
		ramp_request <= 1'b0;
		acc(1'b1, TUNE_OFFSET, 16'h0063);
		ramp_request <= 1'b1;
		cycles(4);
		acc(1'b0, RAMP_STAT_OFFSET, 16'h0);
		check(q, 16'h1);
		finish_test;
	end
endmodule // backlight_ramp_fault_config_tb_top
`default_nettype wire
